// File: shared/aur_defines.svh
// Register offsets, field positions, reset values and bit timing of the receiver.
// Included by the receiver top module and the testbench; holds definitions only.
`ifndef AUR_DEFINES_SVH
`define AUR_DEFINES_SVH

// Byte offsets on the APB bus
`define AUR_OFF_RECEIVE_STATUS_CONTROL 8'h00
`define AUR_OFF_RXDATA 8'h04
`define AUR_OFF_TRANSMIT_STATUS_CONTROL 8'h08
`define AUR_OFF_BAUDCON 8'h0c
`define AUR_OFF_BRGL 8'h10
`define AUR_OFF_BRGH 8'h14
`define AUR_OFF_INTEN 8'h18
`define AUR_OFF_ISTAT 8'h1c
`define AUR_OFF_IMASK 8'h20

// receive_status_control fields
`define AUR_RECEIVE_STATUS_CONTROL_SERIAL_PORT_ENABLE 7
`define AUR_RECEIVE_STATUS_CONTROL_RX9 6
`define AUR_RECEIVE_STATUS_CONTROL_CONTINUOUS_RECEIVE_ENABLE 4
`define AUR_RECEIVE_STATUS_CONTROL_FRAMING_ERROR_BIT 2
`define AUR_RECEIVE_STATUS_CONTROL_OVERRUN_ERROR_BIT 1
`define AUR_RECEIVE_STATUS_CONTROL_NINTH_RECEIVED_BIT 0
// transmit_status_control: only the synchronous-mode select matters here
`define AUR_TRANSMIT_STATUS_CONTROL_SYNC 4
// baud_control: receiver idle
`define AUR_BAUD_RCIDL 6
// Interrupt enable bits
`define AUR_INTEN_RECEIVE_INTERRUPT_ENABLE 0
`define AUR_INTEN_PERIPHERAL_INTERRUPT_ENABLE 1
`define AUR_INTEN_GIE 2
// Sticky event bits
`define AUR_EVT_RX 0
`define AUR_EVT_OVR 1
`define AUR_EVT_W 2

// Reset values
`define AUR_RST_BYTE 8'h00
`define AUR_RST_BRG 16'h0000

// Oversampling: sixteen ticks per bit
`define AUR_OVS 16
`define AUR_HALF_LAST 4'h7
`define AUR_FULL_LAST 4'hf
`define AUR_VOTE_FIRST 4'hd

`endif

// File: shared/aur_pkg.sv
// Types shared by the receiver, its FIFO and the FIFO interface.
// Assumes nothing beyond a SystemVerilog compiler.
package aur_pkg;
   typedef enum logic [3:0] {
      ST_IDLE = 4'b0001,
      ST_START = 4'b0010,
      ST_DATA = 4'b0100,
      ST_STOP = 4'b1000
   } aur_state_e;

   typedef logic [8:0] aur_char_t;

   typedef struct packed {
      logic framing_error_bit;
      aur_char_t data;
   } aur_entry_s;
endpackage

// File: shared/aur_fifo_if.sv
// Link between the receiver core and its character FIFO.
// Assumes both ends run on the same clock and clock enable.
`timescale 1ns/1ns
`default_nettype none
interface aur_fifo_if;
   logic push;
   aur_pkg::aur_entry_s push_entry;
   logic full;
   logic pop;
   logic flush;
   aur_pkg::aur_entry_s top_entry;
   logic empty;

   modport producer (output push, output push_entry, output pop, output flush,
                     input full, input top_entry, input empty);
   modport store (input push, input push_entry, input pop, input flush,
                  output full, output top_entry, output empty);
endinterface
`default_nettype wire

// File: hw/aur_fifo.sv
// Character FIFO: flip-flop storage addressed by read and write index.
// Assumes push is only offered when not full and pop only when not empty.
`timescale 1ns/1ns
`default_nettype none
module aur_fifo #(
   parameter int DEPTH = 2
) (
   input wire logic clk,
   input wire logic rst,
   input wire logic ce,
   aur_fifo_if.store f
);
   localparam int PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
   localparam int CW = $clog2(DEPTH + 1);

   aur_pkg::aur_entry_s mem_q [DEPTH];
   logic [PW-1:0] wp_q;
   logic [PW-1:0] rp_q;
   logic [CW-1:0] cnt_q;
   logic do_push;
   logic do_pop;

   function automatic logic [PW-1:0] inc(input logic [PW-1:0] p);
      inc = (p == PW'(DEPTH - 1)) ? '0 : p + PW'(1);
   endfunction

   assign do_push = f.push & ~f.full;
   assign do_pop = f.pop & ~f.empty;
   assign f.full = (cnt_q == CW'(DEPTH));
   assign f.empty = (cnt_q == '0);
   assign f.top_entry = mem_q[rp_q];

   always_ff @(posedge clk) begin
      if (do_push && ce && !rst && !f.flush) begin
         mem_q[wp_q] <= f.push_entry;
      end
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         wp_q <= '0;
         rp_q <= '0;
         cnt_q <= '0;
      end else if (ce) begin
         if (f.flush) begin
            wp_q <= '0;
            rp_q <= '0;
            cnt_q <= '0;
         end else begin
            if (do_push) begin
               wp_q <= inc(wp_q);
            end
            if (do_pop) begin
               rp_q <= inc(rp_q);
            end
            if (do_push && !do_pop) begin
               cnt_q <= cnt_q + CW'(1);
            end else if (do_pop && !do_push) begin
               cnt_q <= cnt_q - CW'(1);
            end
         end
      end
   end
endmodule
`default_nettype wire

// File: hw/aur_baud.sv
// Oversampling tick: one pulse every divisor+1 clocks, sixteen per bit.
// Assumes the divisor is stable while run is high.
`timescale 1ns/1ns
`default_nettype none
module aur_baud #(
   parameter int DW = 16
) (
   input wire logic clk,
   input wire logic rst,
   input wire logic ce,
   input wire logic run,
   input wire logic [DW-1:0] divisor,
   output logic tick
);
   logic [DW-1:0] cnt_q;

   always_ff @(posedge clk) begin
      if (rst) begin
         cnt_q <= '0;
         tick <= 1'b0;
      end else if (ce) begin
         if (!run) begin
            cnt_q <= '0;
            tick <= 1'b0;
         end else if (cnt_q == divisor) begin
            cnt_q <= '0;
            tick <= 1'b1;
         end else begin
            cnt_q <= cnt_q + DW'(1);
            tick <= 1'b0;
         end
      end
   end
endmodule
`default_nettype wire

// File: hw/aur_rx_top.sv
// Asynchronous serial receiver with APB register access and level interrupt.
// Assumes the receive pin is already synchronous to CLK; one clock domain.
//
// Our own choices: the register offsets and register access over APB.
`timescale 1ns/1ns
`default_nettype none
`include "aur_defines.svh"

module aur_rx_top #(
   parameter int FIFO_DEPTH = 2,
   parameter int AW = 8
) (
   input wire logic CLK,
   input wire logic RESET,
   input wire logic CE,
   input wire logic PSEL,
   input wire logic PENABLE,
   input wire logic PWRITE,
   input wire logic [AW-1:0] PADDR,
   input wire logic [31:0] PWDATA,
   output logic [31:0] PRDATA,
   output logic PREADY,
   output logic PSLVERR,
   input wire logic RECEIVE_PIN,
   output logic RECEIVE_PENDING_FLAG,
   output logic IRQ
);
   ////////////////////////////////////////////////////////////////////////////
   // Declarations
   aur_fifo_if fif ();

   logic serial_port_enable_q;
   logic nine_bit_receive_select_q;
   logic continuous_receive_enable_q;
   logic sync_q;
   logic [15:0] brg_q;
   logic receive_interrupt_enable_q;
   logic peripheral_interrupt_enable_q;
   logic global_interrupt_enable_q;
   logic [`AUR_EVT_W-1:0] sts_q;
   logic [`AUR_EVT_W-1:0] mask_q;
   logic [`AUR_EVT_W-1:0] sts_set;
   logic overrun_error_bit_q;
   logic receive_pending_flag_q;
   logic irq_q;
   logic [31:0] prdata_q;
   logic pready_q;
   logic pslverr_q;
   logic [31:0] rdata;
   logic mapped;

   aur_pkg::aur_state_e state_q;
   logic [3:0] cnt_q;
   logic [3:0] bitn_q;
   logic [8:0] receive_shift_register_q;
   logic [1:0] vote_q;
   logic pin_prev_q;

   logic rx_en;
   logic tick;
   logic access;
   logic done;
   logic wr;
   logic rd;
   logic data_bit;
   logic stop_done;
   logic ovr_evt;
   logic [3:0] last_bit;

   function automatic logic maj3(input logic a, input logic b, input logic c);
      maj3 = (a & b) | (a & c) | (b & c);
   endfunction

   function automatic logic hit(input logic [AW-1:0] a, input logic [7:0] off);
      hit = (a == AW'(off));
   endfunction

   ////////////////////////////////////////////////////////////////////////////
   // Submodules
   aur_baud #(
      .DW(16)
   ) u_baud (
      .clk(CLK),
      .rst(RESET),
      .ce(CE),
      .run(rx_en),
      .divisor(brg_q),
      .tick(tick)
   );

   aur_fifo #(
      .DEPTH(FIFO_DEPTH)
   ) u_fifo (
      .clk(CLK),
      .rst(RESET),
      .ce(CE),
      .f(fif.store)
   );

   ////////////////////////////////////////////////////////////////////////////
   // APB slave: one wait state, so every transfer answers in its second access cycle
   assign access = PSEL & PENABLE;
   assign done = access & pready_q;
   assign wr = done & PWRITE;
   assign rd = done & ~PWRITE;

   always_comb begin
      rdata = 32'h0000_0000;
      mapped = 1'b1;
      case (PADDR)
         AW'(`AUR_OFF_RECEIVE_STATUS_CONTROL): begin
            rdata[`AUR_RECEIVE_STATUS_CONTROL_SERIAL_PORT_ENABLE] = serial_port_enable_q;
            rdata[`AUR_RECEIVE_STATUS_CONTROL_RX9] = nine_bit_receive_select_q;
            rdata[`AUR_RECEIVE_STATUS_CONTROL_CONTINUOUS_RECEIVE_ENABLE] = continuous_receive_enable_q;
            rdata[`AUR_RECEIVE_STATUS_CONTROL_FRAMING_ERROR_BIT] = fif.top_entry.framing_error_bit & ~fif.empty;
            rdata[`AUR_RECEIVE_STATUS_CONTROL_OVERRUN_ERROR_BIT] = overrun_error_bit_q;
            rdata[`AUR_RECEIVE_STATUS_CONTROL_NINTH_RECEIVED_BIT] = fif.top_entry.data[8] & ~fif.empty;
         end
         AW'(`AUR_OFF_RXDATA): begin
            rdata[7:0] = fif.empty ? `AUR_RST_BYTE : fif.top_entry.data[7:0];
         end
         AW'(`AUR_OFF_TRANSMIT_STATUS_CONTROL): begin
            rdata[`AUR_TRANSMIT_STATUS_CONTROL_SYNC] = sync_q;
         end
         AW'(`AUR_OFF_BAUDCON): begin
            rdata[`AUR_BAUD_RCIDL] = (state_q == aur_pkg::ST_IDLE);
         end
         AW'(`AUR_OFF_BRGL): begin
            rdata[7:0] = brg_q[7:0];
         end
         AW'(`AUR_OFF_BRGH): begin
            rdata[7:0] = brg_q[15:8];
         end
         AW'(`AUR_OFF_INTEN): begin
            rdata[`AUR_INTEN_RECEIVE_INTERRUPT_ENABLE] = receive_interrupt_enable_q;
            rdata[`AUR_INTEN_PERIPHERAL_INTERRUPT_ENABLE] = peripheral_interrupt_enable_q;
            rdata[`AUR_INTEN_GIE] = global_interrupt_enable_q;
         end
         AW'(`AUR_OFF_ISTAT): begin
            rdata[`AUR_EVT_W-1:0] = sts_q;
         end
         AW'(`AUR_OFF_IMASK): begin
            rdata[`AUR_EVT_W-1:0] = mask_q;
         end
         default: begin
            mapped = 1'b0;
         end
      endcase
   end

   always_ff @(posedge CLK) begin
      if (RESET) begin
         pready_q <= 1'b0;
         prdata_q <= 32'h0000_0000;
         pslverr_q <= 1'b0;
      end else if (CE) begin
         pready_q <= access & ~pready_q;
         if (access && !pready_q) begin
            prdata_q <= PWRITE ? 32'h0000_0000 : rdata;
            pslverr_q <= ~mapped;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Control registers
   always_ff @(posedge CLK) begin
      if (RESET) begin
         serial_port_enable_q <= 1'b0;
         nine_bit_receive_select_q <= 1'b0;
         continuous_receive_enable_q <= 1'b0;
         sync_q <= 1'b0;
         brg_q <= `AUR_RST_BRG;
         receive_interrupt_enable_q <= 1'b0;
         peripheral_interrupt_enable_q <= 1'b0;
         global_interrupt_enable_q <= 1'b0;
         mask_q <= '0;
      end else if (CE && wr) begin
         if (hit(PADDR, `AUR_OFF_RECEIVE_STATUS_CONTROL)) begin
            serial_port_enable_q <= PWDATA[`AUR_RECEIVE_STATUS_CONTROL_SERIAL_PORT_ENABLE];
            nine_bit_receive_select_q <= PWDATA[`AUR_RECEIVE_STATUS_CONTROL_RX9];
            continuous_receive_enable_q <= PWDATA[`AUR_RECEIVE_STATUS_CONTROL_CONTINUOUS_RECEIVE_ENABLE];
         end
         if (hit(PADDR, `AUR_OFF_TRANSMIT_STATUS_CONTROL)) begin
            sync_q <= PWDATA[`AUR_TRANSMIT_STATUS_CONTROL_SYNC];
         end
         if (hit(PADDR, `AUR_OFF_BRGL)) begin
            brg_q[7:0] <= PWDATA[7:0];
         end
         if (hit(PADDR, `AUR_OFF_BRGH)) begin
            brg_q[15:8] <= PWDATA[7:0];
         end
         if (hit(PADDR, `AUR_OFF_INTEN)) begin
            receive_interrupt_enable_q <= PWDATA[`AUR_INTEN_RECEIVE_INTERRUPT_ENABLE];
            peripheral_interrupt_enable_q <= PWDATA[`AUR_INTEN_PERIPHERAL_INTERRUPT_ENABLE];
            global_interrupt_enable_q <= PWDATA[`AUR_INTEN_GIE];
         end
         if (hit(PADDR, `AUR_OFF_IMASK)) begin
            mask_q <= PWDATA[`AUR_EVT_W-1:0];
         end
      end
   end

   assign rx_en = continuous_receive_enable_q & ~sync_q & serial_port_enable_q;

   ////////////////////////////////////////////////////////////////////////////
   // Data recovery; the pin idles high and bits arrive LSB first
   assign last_bit = nine_bit_receive_select_q ? 4'h8 : 4'h7;
   assign data_bit = maj3(vote_q[1], vote_q[0], RECEIVE_PIN);
   assign stop_done = tick & (state_q == aur_pkg::ST_STOP) & (cnt_q == `AUR_FULL_LAST);

   always_ff @(posedge CLK) begin
      if (RESET) begin
         state_q <= aur_pkg::ST_IDLE;
         cnt_q <= 4'h0;
         bitn_q <= 4'h0;
         receive_shift_register_q <= 9'h000;
         vote_q <= 2'h3;
         pin_prev_q <= 1'b1;
      end else if (CE) begin
         pin_prev_q <= RECEIVE_PIN;
         if (!rx_en) begin
            state_q <= aur_pkg::ST_IDLE;
            cnt_q <= 4'h0;
         end else begin
            if (tick && cnt_q >= `AUR_VOTE_FIRST) begin
               vote_q <= {vote_q[0], RECEIVE_PIN};
            end
            case (state_q)
               aur_pkg::ST_IDLE: begin
                  cnt_q <= 4'h0;
                  if (pin_prev_q && !RECEIVE_PIN) begin
                     state_q <= aur_pkg::ST_START;
                  end
               end
               aur_pkg::ST_START: begin
                  if (tick) begin
                     cnt_q <= cnt_q + 4'h1;
                     if (cnt_q == `AUR_HALF_LAST) begin
                        cnt_q <= 4'h0;
                        bitn_q <= 4'h0;
                        // A glitch shorter than half a bit is dropped without an error
                        state_q <= RECEIVE_PIN ? aur_pkg::ST_IDLE : aur_pkg::ST_DATA;
                     end
                  end
               end
               aur_pkg::ST_DATA: begin
                  if (tick) begin
                     cnt_q <= cnt_q + 4'h1;
                     if (cnt_q == `AUR_FULL_LAST) begin
                        receive_shift_register_q <= {data_bit, receive_shift_register_q[8:1]};
                        bitn_q <= bitn_q + 4'h1;
                        if (bitn_q == last_bit) begin
                           state_q <= aur_pkg::ST_STOP;
                        end
                     end
                  end
               end
               aur_pkg::ST_STOP: begin
                  if (tick) begin
                     cnt_q <= cnt_q + 4'h1;
                     if (cnt_q == `AUR_FULL_LAST) begin
                        state_q <= aur_pkg::ST_IDLE;
                     end
                  end
               end
               default: begin
                  state_q <= aur_pkg::ST_IDLE;
               end
            endcase
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // FIFO hand-off, overrun lockout and flags
   // In eight-bit mode the shifter is one place short, so realign
   assign fif.push_entry.data = nine_bit_receive_select_q ? receive_shift_register_q
                                : {1'b0, receive_shift_register_q[8:1]};
   assign fif.push_entry.framing_error_bit = ~data_bit;
   // A framing error does not block the hand-off
   assign fif.push = CE & rx_en & stop_done & ~overrun_error_bit_q & ~fif.full;
   assign ovr_evt = CE & rx_en & stop_done & ~overrun_error_bit_q & fif.full;
   assign fif.pop = rd & hit(PADDR, `AUR_OFF_RXDATA);
   assign fif.flush = ~serial_port_enable_q;

   always_ff @(posedge CLK) begin
      if (RESET) begin
         overrun_error_bit_q <= 1'b0;
      end else if (CE) begin
         // Lockout holds until receive enable or port enable drops
         overrun_error_bit_q <= ovr_evt | (overrun_error_bit_q & continuous_receive_enable_q
                                & serial_port_enable_q);
      end
   end

   always_ff @(posedge CLK) begin
      if (RESET) begin
         receive_pending_flag_q <= 1'b0;
      end else if (CE) begin
         receive_pending_flag_q <= rx_en & ~fif.empty;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Interrupts: sticky events with write-one-to-clear; a new event beats the clear
   assign sts_set[`AUR_EVT_RX] = fif.push;
   assign sts_set[`AUR_EVT_OVR] = ovr_evt;

   always_ff @(posedge CLK) begin
      if (RESET) begin
         sts_q <= '0;
      end else if (CE) begin
         if (wr && hit(PADDR, `AUR_OFF_ISTAT)) begin
            sts_q <= (sts_q & ~PWDATA[`AUR_EVT_W-1:0]) | sts_set;
         end else begin
            sts_q <= sts_q | sts_set;
         end
      end
   end

   always_ff @(posedge CLK) begin
      if (RESET) begin
         irq_q <= 1'b0;
      end else if (CE) begin
         irq_q <= (receive_pending_flag_q & receive_interrupt_enable_q
                   & peripheral_interrupt_enable_q & global_interrupt_enable_q)
                  | (|(sts_q & mask_q));
      end
   end

   assign PRDATA = prdata_q;
   assign PREADY = pready_q;
   assign PSLVERR = pslverr_q;
   assign RECEIVE_PENDING_FLAG = receive_pending_flag_q;
   assign IRQ = irq_q;

   ////////////////////////////////////////////////////////////////////////////
   // Checks
   default clocking cb @(posedge CLK); endclocking
   default disable iff (RESET);

   a_pending_track: assert property (CE |=> RECEIVE_PENDING_FLAG == $past(rx_en && !fif.empty))
      else $error("pending flag does not track FIFO");
   a_irq_gated: assert property (CE && !(receive_interrupt_enable_q && peripheral_interrupt_enable_q
      && global_interrupt_enable_q) && (sts_q & mask_q) == '0 |=> !IRQ)
      else $error("interrupt without enables");
   a_start_abort: assert property (CE && rx_en && tick && state_q == aur_pkg::ST_START
      && cnt_q == `AUR_HALF_LAST && RECEIVE_PIN |=> state_q == aur_pkg::ST_IDLE
      && !overrun_error_bit_q == !$past(overrun_error_bit_q))
      else $error("false start not dropped");
   a_overrun_set: assert property (ovr_evt |=> overrun_error_bit_q && fif.full)
      else $error("overrun not flagged");
   a_overrun_hold: assert property (CE && overrun_error_bit_q && continuous_receive_enable_q
      && serial_port_enable_q |=> overrun_error_bit_q)
      else $error("overrun cleared early");
   a_port_flush: assert property (CE && !serial_port_enable_q |=> fif.empty
      && !overrun_error_bit_q ##1 !RECEIVE_PENDING_FLAG)
      else $error("port disable left state");
   a_framing_error_bit_accept: assert property (CE && rx_en && stop_done && !data_bit
      && !fif.full && !overrun_error_bit_q |-> fif.push)
      else $error("framing error blocked character");
   a_pop_read: assert property (CE && fif.pop && fif.full && !fif.push |=> !fif.full)
      else $error("read did not advance FIFO");
   a_framing_error_bit_visible: assert property (CE && access && !pready_q && !PWRITE
      && hit(PADDR, `AUR_OFF_RECEIVE_STATUS_CONTROL) |=> PREADY
      && PRDATA[`AUR_RECEIVE_STATUS_CONTROL_FRAMING_ERROR_BIT] == $past(fif.top_entry.framing_error_bit && !fif.empty))
      else $error("framing bit not of top entry");

   c_overrun: cover property (ovr_evt);
   c_frame_err: cover property (fif.push && fif.push_entry.framing_error_bit);
   c_nine_bit: cover property (fif.push && nine_bit_receive_select_q && fif.push_entry.data[8]);
   c_false_start: cover property (state_q == aur_pkg::ST_START ##1 state_q == aur_pkg::ST_IDLE);
endmodule
`default_nettype wire

// File: verification/aur_line_model.sv
// Remote serial transmitter model that drives the receive line.
// Assumes every call starts right after a rising edge of clk.
`timescale 1ns/1ns
`default_nettype none
module aur_line_model (
   input wire logic clk,
   output logic line
);
   int bit_clks = 16;

   initial line = 1'b1;

   task automatic put(input logic lvl, input int clks);
      line <= lvl;
      repeat (clks) @(posedge clk);
   endtask

   task automatic send(input logic [8:0] d, input int nbits, input logic stop_lvl);
      put(1'b0, bit_clks);
      for (int i = 0; i < nbits; i++) begin
         put(d[i], bit_clks);
      end
      // A low stop is a deliberate framing fault; mark follows so the next edge is clean
      put(stop_lvl, bit_clks);
      put(1'b1, 2 * bit_clks);
   endtask

   // Short low pulse that must not survive the mid-start check
   task automatic glitch();
      put(1'b0, 3);
      put(1'b1, 2 * bit_clks);
   endtask
endmodule
`default_nettype wire

// File: verification/testbench.sv
// Self-checking bench: APB register tasks plus a serial line model.
// Assumes the design answers APB within a few cycles and CE may stay high.
`timescale 1ns/1ns
`default_nettype none
`include "aur_defines.svh"
module testbench;
   logic clk, reset, ce, psel, penable, pwrite, pready, pslverr, pin_rx, pend, irq;
   logic [7:0] paddr;
   logic [31:0] pwdata, prdata, rdat;
   logic rerr;
   int fails, check_count;

   aur_rx_top u_dut (.CLK(clk), .RESET(reset), .CE(ce), .PSEL(psel), .PENABLE(penable),
      .PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata), .PREADY(pready),
      .PSLVERR(pslverr), .RECEIVE_PIN(pin_rx), .RECEIVE_PENDING_FLAG(pend), .IRQ(irq));
   aur_line_model u_line (.clk(clk), .line(pin_rx));

   ////////////////////////////////////////////////////////////////////////////////
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      check_count++;
      if (got !== exp) begin
         fails++;
         $display("MISMATCH t=%0t got %h exp %h", $time, got, exp);
      end
   endtask

   // One edge passes after release so the next setup never lands in the same step
   task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] wd);
      int n;
      n = 0;
      psel <= 1'b1;
      pwrite <= wr;
      paddr <= a;
      pwdata <= wd;
      @(posedge clk);
      penable <= 1'b1;
      // Looked at mid-cycle: what stands here is what the next rising edge samples
      do begin
         @(negedge clk);
         n++;
      end while (pready !== 1'b1 && n < 50);
      if (n >= 50) chk(32'(n), 32'h0);
      rdat = prdata;
      rerr = pslverr;
      @(posedge clk);
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge clk);
   endtask

   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      apb(1'b1, a, d);
   endtask

   task automatic rd(input logic [7:0] a, input logic [31:0] exp);
      apb(1'b0, a, 32'h0);
      chk(rdat, exp);
   endtask

   task automatic pins(input logic [1:0] e);
      repeat (2) @(negedge clk);
      chk({30'h0, pend, irq}, {30'h0, e});
      @(posedge clk);
   endtask

   task automatic final_report;
      $display("fails=%0d check_count=%0d", fails, check_count);
      if (fails == 0 && check_count > 0) begin
         $display("ALL TESTS PASSED");
      end else begin
         $display("TESTS FAILED");
      end
      $finish;
   endtask

   ////////////////////////////////////////////////////////////////////////////////
   initial begin
      clk = 1'b0;
      forever #50 clk = ~clk;
   end

   // About 4300 cycles of traffic are expected
   initial begin
      #4_000_000;
      fails++;
      final_report();
   end

   initial begin
      reset = 1'b1;
      ce = 1'b1;
      psel = 1'b0;
      penable = 1'b0;
      pwrite = 1'b0;
      paddr = 8'h00;
      pwdata = 32'h0;
      fails = 0;
      check_count = 0;
      repeat (4) @(posedge clk);
      reset <= 1'b0;
      @(posedge clk);
      rd(`AUR_OFF_RECEIVE_STATUS_CONTROL, 32'h0);
      rd(8'h40, 32'h0);
      chk({31'h0, rerr}, 32'h1);
      wr(`AUR_OFF_RECEIVE_STATUS_CONTROL, 32'h90);
      wr(`AUR_OFF_INTEN, 32'h7);
      u_line.glitch();
      pins(2'b00);
      rd(`AUR_OFF_BAUDCON, 32'h40);
      u_line.send(9'h0a5, 8, 1'b1);
      pins(2'b11);
      rd(`AUR_OFF_ISTAT, 32'h1);
      rd(`AUR_OFF_RXDATA, 32'ha5);
      pins(2'b00);
      u_line.send(9'h00f, 8, 1'b1);
      for (int v = 0; v < 8; v++) begin
         wr(`AUR_OFF_INTEN, 32'(v));
         pins({1'b1, v == 7});
      end
      rd(`AUR_OFF_RXDATA, 32'h0f);
      wr(`AUR_OFF_INTEN, 32'h0);
      wr(`AUR_OFF_IMASK, 32'h1);
      pins(2'b01);
      wr(`AUR_OFF_ISTAT, 32'h1);
      pins(2'b00);
      wr(`AUR_OFF_IMASK, 32'h0);
      u_line.send(9'h03c, 8, 1'b0);
      u_line.send(9'h05a, 8, 1'b1);
      rd(`AUR_OFF_RECEIVE_STATUS_CONTROL, 32'h94);
      rd(`AUR_OFF_RXDATA, 32'h3c);
      rd(`AUR_OFF_RECEIVE_STATUS_CONTROL, 32'h90);
      rd(`AUR_OFF_RXDATA, 32'h5a);
      u_line.send(9'h011, 8, 1'b1);
      u_line.send(9'h022, 8, 1'b1);
      u_line.send(9'h033, 8, 1'b1);
      u_line.send(9'h044, 8, 1'b1);
      rd(`AUR_OFF_RECEIVE_STATUS_CONTROL, 32'h92);
      rd(`AUR_OFF_ISTAT, 32'h3);
      rd(`AUR_OFF_RXDATA, 32'h11);
      rd(`AUR_OFF_RXDATA, 32'h22);
      pins(2'b00);
      rd(`AUR_OFF_RECEIVE_STATUS_CONTROL, 32'h92);
      wr(`AUR_OFF_RECEIVE_STATUS_CONTROL, 32'h80);
      rd(`AUR_OFF_RECEIVE_STATUS_CONTROL, 32'h80);
      wr(`AUR_OFF_RECEIVE_STATUS_CONTROL, 32'h90);
      u_line.send(9'h066, 8, 1'b1);
      rd(`AUR_OFF_RXDATA, 32'h66);
      u_line.send(9'h077, 8, 1'b0);
      wr(`AUR_OFF_RECEIVE_STATUS_CONTROL, 32'h80);
      pins(2'b00);
      rd(`AUR_OFF_RECEIVE_STATUS_CONTROL, 32'h84);
      wr(`AUR_OFF_RECEIVE_STATUS_CONTROL, 32'h00);
      wr(`AUR_OFF_RECEIVE_STATUS_CONTROL, 32'h90);
      rd(`AUR_OFF_RECEIVE_STATUS_CONTROL, 32'h90);
      pins(2'b00);
      wr(`AUR_OFF_RECEIVE_STATUS_CONTROL, 32'hd0);
      u_line.send(9'h1c3, 9, 1'b1);
      rd(`AUR_OFF_RECEIVE_STATUS_CONTROL, 32'hd1);
      rd(`AUR_OFF_RXDATA, 32'hc3);
      wr(`AUR_OFF_RECEIVE_STATUS_CONTROL, 32'h90);
      // Slower rate: a receiver not tied to the divisor loses the character
      wr(`AUR_OFF_BRGL, 32'h1);
      rd(`AUR_OFF_BRGL, 32'h1);
      u_line.bit_clks = 32;
      u_line.send(9'h096, 8, 1'b1);
      rd(`AUR_OFF_RXDATA, 32'h96);
      wr(`AUR_OFF_TRANSMIT_STATUS_CONTROL, 32'h10);
      u_line.send(9'h055, 8, 1'b1);
      pins(2'b00);
      wr(`AUR_OFF_TRANSMIT_STATUS_CONTROL, 32'h0);
      wr(`AUR_OFF_RECEIVE_STATUS_CONTROL, 32'h10);
      u_line.send(9'h055, 8, 1'b1);
      wr(`AUR_OFF_RECEIVE_STATUS_CONTROL, 32'h90);
      pins(2'b00);
      // Port on but receive enable off: the FIFO is kept, so a taken character would show
      wr(`AUR_OFF_RECEIVE_STATUS_CONTROL, 32'h80);
      u_line.send(9'h055, 8, 1'b1);
      wr(`AUR_OFF_RECEIVE_STATUS_CONTROL, 32'h90);
      pins(2'b00);
      // Clock enable low freezes the receiver, so this character is never taken
      ce <= 1'b0;
      u_line.send(9'h0a5, 8, 1'b1);
      ce <= 1'b1;
      pins(2'b00);
      final_report();
   end
endmodule
`default_nettype wire
